// *** hw/mfr_pkg.sv ***
package mfr_pkg;

  // Instruction codes
  localparam logic [7:0] CMD_QUAD_OUT = 8'h6b;
  localparam logic [7:0] CMD_DUAL_IO = 8'hbb;
  localparam logic [7:0] CMD_QUAD_IO = 8'heb;
  localparam logic [7:0] CMD_CONT_RESET = 8'hff;

  // Phase lengths in serial clocks
  localparam logic [4:0] CMD_CLKS = 5'h08;
  localparam logic [4:0] ADDR_CLKS_X1 = 5'h18;
  localparam logic [4:0] ADDR_CLKS_X2 = 5'h0c;
  localparam logic [4:0] ADDR_CLKS_X4 = 5'h06;
  localparam logic [4:0] QOUT_DUMMY = 5'h08;
  localparam logic [4:0] DIO_MODE_CLKS = 5'h04;
  localparam logic [4:0] DIO_DUMMY = 5'h00;
  localparam logic [4:0] QIO_MODE_CLKS = 5'h02;
  localparam logic [4:0] QIO_DUMMY = 5'h04;

  // Continuous mode byte
  localparam logic [1:0] CONT_SEL_KEEP = 2'h2;
  localparam int CONT_SEL_LSB = 4;

  // Wrap setting: bit 0 disables, bits 2:1 pick length
  localparam logic [2:0] WRAP_RST = 3'h1;
  localparam int WRAP_DIS_BIT = 0;
  localparam int WRAP_LEN_LSB = 1;
  localparam logic [23:0] WRAP_MASK_8 = 24'h000007;
  localparam logic [23:0] WRAP_MASK_16 = 24'h00000f;
  localparam logic [23:0] WRAP_MASK_32 = 24'h00001f;
  localparam logic [23:0] WRAP_MASK_64 = 24'h00003f;

  // Synchroniser layout: sck, cs_n, io[3:0]
  localparam int PIN_SCK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_IO_LSB = 2;
  localparam logic [5:0] SYNC_RST = 6'h02;

  // Output lanes and data buffer
  localparam logic [3:0] LANES_X2 = 4'h3;
  localparam logic [3:0] LANES_X4 = 4'hf;
  localparam logic [1:0] BYTE_CLKS_X2 = 2'h3;
  localparam logic [1:0] BYTE_CLKS_X4 = 2'h1;
  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] PEND_MAX = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
  } mfr_state_type;

  typedef enum logic [1:0] {KIND_QOUT, KIND_DIO, KIND_QIO} mfr_kind_type;

endpackage

// *** hw/mfr_buf.sv ***
`timescale 1ns/1ps
`default_nettype none

module mfr_buf #(
  parameter int WIDTH = mfr_pkg::BUF_WIDTH,
  parameter int DEPTH = mfr_pkg::BUF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  always_comb begin
    if (flush) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      // Ready is registered so the source sees a clean level
      in_ready <= (cnt_nxt != CW'(DEPTH));
      if (flush) begin
        wp_r <= '0;
        rp_r <= '0;
      end else begin
        if (push) begin
          wp_r <= bump(wp_r);
        end
        if (pop) begin
          rp_r <= bump(rp_r);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push && !flush) begin
      mem_r[wp_r] <= in_data;
    end
  end

endmodule

`default_nettype wire

// *** hw/mfr_engine.sv ***
// Function
// [R01] Quad-output read returns data on all four lines.
// [R02] Quad-output read refused unless quad enable bit is one.
// [R03] Quad-output read: eight dummy clocks after 24-bit address by default.
// [R04] Host releases lines before the first data falling edge.
// [R05] Variable latency sets quad-output dummy count from latency field.
// [R06] Dual address-and-data read moves address and data on two lines.
// [R07] Mode byte: lower nibble ignored, upper nibble steers next frame.
// [R08] Host may leave lower mode nibble undriven for turnaround.
// [R09] Select bits 10: next frame skips instruction, address first.
// [R10] Other select values: next frame needs its instruction byte.
// [R11] All-ones reset pattern clears continuous mode.
// [R12] Dual read legacy latency: four mode clocks, no dummy.
// [R13] Variable latency sets mode-plus-dummy total for both reads.
// [R14] Quad address-and-data read uses four lines, four dummy clocks.
// [R15] Quad address-and-data read needs the quad enable bit.
// [R16] Quad address-and-data legacy latency: two mode plus four dummy.
// [R17] Wrap setting applies to later quad address-and-data reads.
// [R18] Wrap on: output wraps inside the aligned section until deselect.
// [R19] Wrap disable bit switches wrapping; length bits pick section size.
// [R20] Wrap disable bit resets to one, wrapping off.
// [R21] Host clocks reset pattern eight clocks quad, sixteen dual.
// [R22] Address advances after every output byte.
// [R23] Quad-output read: instruction and address on one line.
// [R24] Refused quad read ignored, lines left undriven.
`timescale 1ns/1ps
`default_nettype none

module mfr_engine (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic spi_clk_pin,
  input wire logic spi_cs_n_pin,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_enable_bit,
  input wire logic var_latency_en,
  input wire logic [3:0] read_latency,
  input wire logic wrap_set_stb,
  input wire logic [2:0] wrap_setting_bits,
  output logic mem_rd,
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  output logic mem_rready,
  output logic cont_active
);

  logic [5:0] s1_r, s2_r, s3_r, f_r, f_nxt;
  logic sck_q_r, cs_q_r;
  logic sck_rise, sck_fall, frame_start, frame_end;
  logic [3:0] io;
  mfr_pkg::mfr_state_type state_r;
  mfr_pkg::mfr_kind_type kind_r, cont_kind_r;
  logic [4:0] cnt_r, len_r, dummy;
  logic last;
  logic [23:0] sh_r, sh_nxt;
  logic [7:0] cmd_byte;
  logic [2:0] wrap_bits_r;
  logic [23:0] fetch_addr_r;
  logic fetch_on_r, wrap_on_r, inflight_r, drop_r;
  logic [1:0] pend_r;
  logic issue, hs, flush, pop;
  logic buf_valid;
  logic [7:0] buf_data, src;
  logic [1:0] dcnt_r;
  logic [7:0] dsr_r;
  logic x4;

  function automatic logic [23:0] shift_in(input logic [23:0] v,
                                           input logic [3:0] d,
                                           input logic [4:0] w);
    case (w)
      5'h01: return {v[22:0], d[0]};
      5'h02: return {v[21:0], d[1:0]};
      default: return {v[19:0], d};
    endcase
  endfunction

  // Lines per clock while the host shifts in
  function automatic logic [4:0] in_width(input mfr_pkg::mfr_state_type s,
                                          input mfr_pkg::mfr_kind_type k);
    if (s == mfr_pkg::ST_CMD || k == mfr_pkg::KIND_QOUT) begin
      return 5'h01; // [R23]
    end else if (k == mfr_pkg::KIND_DIO) begin
      return 5'h02; // [R06]
    end else begin
      return 5'h04; // [R14]
    end
  endfunction

  function automatic logic [4:0] addr_clks(input mfr_pkg::mfr_kind_type k);
    case (k)
      mfr_pkg::KIND_QOUT: return mfr_pkg::ADDR_CLKS_X1;
      mfr_pkg::KIND_DIO: return mfr_pkg::ADDR_CLKS_X2;
      default: return mfr_pkg::ADDR_CLKS_X4;
    endcase
  endfunction

  // Mode clocks are a floor; a shorter latency field cannot cut them
  function automatic logic [4:0] dummy_clks(input mfr_pkg::mfr_kind_type k,
                                            input logic en,
                                            input logic [3:0] lat);
    logic [4:0] l;
    l = {1'b0, lat};
    case (k)
      mfr_pkg::KIND_QOUT:
        return en ? l : mfr_pkg::QOUT_DUMMY; // [R03] [R05]
      mfr_pkg::KIND_DIO:
        if (!en) begin
          return mfr_pkg::DIO_DUMMY; // [R12]
        end else begin
          return (l > mfr_pkg::DIO_MODE_CLKS) ?
                 5'(l - mfr_pkg::DIO_MODE_CLKS) : 5'h00; // [R13]
        end
      default:
        if (!en) begin
          return mfr_pkg::QIO_DUMMY; // [R16]
        end else begin
          return (l > mfr_pkg::QIO_MODE_CLKS) ?
                 5'(l - mfr_pkg::QIO_MODE_CLKS) : 5'h00; // [R13]
        end
    endcase
  endfunction

  function automatic logic [23:0] next_addr(input logic [23:0] a,
                                            input logic wrap,
                                            input logic [1:0] len);
    logic [23:0] m;
    logic [23:0] inc;
    m = mfr_pkg::WRAP_MASK_64;
    inc = 24'(a + 24'h000001);
    case (len)
      2'h0: m = mfr_pkg::WRAP_MASK_8;
      2'h1: m = mfr_pkg::WRAP_MASK_16;
      2'h2: m = mfr_pkg::WRAP_MASK_32;
      default: m = mfr_pkg::WRAP_MASK_64;
    endcase
    return wrap ? ((a & ~m) | (inc & m)) : inc; // [R18] [R22]
  endfunction

  // Pin synchroniser; a change counts once stages two and three agree
  generate
    for (genvar i = 0; i < 6; i++) begin : g_filt
      assign f_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : f_r[i];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= mfr_pkg::SYNC_RST;
      s2_r <= mfr_pkg::SYNC_RST;
      s3_r <= mfr_pkg::SYNC_RST;
      f_r <= mfr_pkg::SYNC_RST;
      sck_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end else begin
      s1_r <= {io_in, spi_cs_n_pin, spi_clk_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
      sck_q_r <= f_r[mfr_pkg::PIN_SCK];
      cs_q_r <= f_r[mfr_pkg::PIN_CS];
    end
  end

  assign io = f_r[mfr_pkg::PIN_IO_LSB +: 4];
  assign sck_rise = f_r[mfr_pkg::PIN_SCK] & ~sck_q_r;
  assign sck_fall = ~f_r[mfr_pkg::PIN_SCK] & sck_q_r;
  assign frame_start = ~f_r[mfr_pkg::PIN_CS] & cs_q_r;
  assign frame_end = f_r[mfr_pkg::PIN_CS] & ~cs_q_r;
  assign last = (cnt_r == 5'(len_r - 5'h01));
  assign sh_nxt = shift_in(sh_r, io, in_width(state_r, kind_r));
  assign cmd_byte = sh_nxt[7:0];
  assign dummy = dummy_clks(kind_r, var_latency_en, read_latency);

  // Command phase sequencer, stepped on serial clock rising edges
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= mfr_pkg::ST_IDLE;
      kind_r <= mfr_pkg::KIND_QOUT;
      cnt_r <= 5'h00;
      len_r <= mfr_pkg::CMD_CLKS;
    end else if (f_r[mfr_pkg::PIN_CS]) begin
      state_r <= mfr_pkg::ST_IDLE;
    end else if (frame_start) begin
      cnt_r <= 5'h00;
      if (cont_active) begin
        state_r <= mfr_pkg::ST_ADDR; // [R09]
        kind_r <= cont_kind_r;
        len_r <= addr_clks(cont_kind_r);
      end else begin
        state_r <= mfr_pkg::ST_CMD; // [R10]
        len_r <= mfr_pkg::CMD_CLKS;
      end
    end else if (sck_rise) begin
      cnt_r <= last ? 5'h00 : 5'(cnt_r + 5'h01);
      case (state_r)
        mfr_pkg::ST_CMD:
          if (last) begin
            state_r <= mfr_pkg::ST_IGNORE;
            case (cmd_byte)
              mfr_pkg::CMD_QUAD_OUT:
                if (quad_enable_bit) begin // [R02] [R24]
                  state_r <= mfr_pkg::ST_ADDR;
                  kind_r <= mfr_pkg::KIND_QOUT;
                  len_r <= mfr_pkg::ADDR_CLKS_X1;
                end
              mfr_pkg::CMD_DUAL_IO: begin
                state_r <= mfr_pkg::ST_ADDR;
                kind_r <= mfr_pkg::KIND_DIO;
                len_r <= mfr_pkg::ADDR_CLKS_X2;
              end
              mfr_pkg::CMD_QUAD_IO:
                if (quad_enable_bit) begin // [R15] [R24]
                  state_r <= mfr_pkg::ST_ADDR;
                  kind_r <= mfr_pkg::KIND_QIO;
                  len_r <= mfr_pkg::ADDR_CLKS_X4;
                end
              default: state_r <= mfr_pkg::ST_IGNORE;
            endcase
          end
        mfr_pkg::ST_ADDR:
          if (last) begin
            if (kind_r == mfr_pkg::KIND_DIO) begin
              state_r <= mfr_pkg::ST_MODE;
              len_r <= mfr_pkg::DIO_MODE_CLKS; // [R12]
            end else if (kind_r == mfr_pkg::KIND_QIO) begin
              state_r <= mfr_pkg::ST_MODE;
              len_r <= mfr_pkg::QIO_MODE_CLKS; // [R16]
            end else begin
              state_r <= (dummy == 5'h00) ? mfr_pkg::ST_DATA
                                          : mfr_pkg::ST_DUMMY; // [R03]
              len_r <= dummy;
            end
          end
        mfr_pkg::ST_MODE:
          if (last) begin
            state_r <= (dummy == 5'h00) ? mfr_pkg::ST_DATA
                                        : mfr_pkg::ST_DUMMY; // [R13]
            len_r <= dummy;
          end
        mfr_pkg::ST_DUMMY:
          if (last) begin
            state_r <= mfr_pkg::ST_DATA;
          end
        default: state_r <= state_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r <= 24'h000000;
    end else if (frame_start) begin
      sh_r <= 24'h000000;
    end else if (sck_rise && (state_r == mfr_pkg::ST_CMD ||
                              state_r == mfr_pkg::ST_ADDR ||
                              state_r == mfr_pkg::ST_MODE)) begin
      sh_r <= sh_nxt;
    end
  end

  // Only select bits matter; an all-ones pattern reads as select 11
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cont_active <= 1'b0;
      cont_kind_r <= mfr_pkg::KIND_DIO;
    end else if (sck_rise && last && state_r == mfr_pkg::ST_MODE) begin
      cont_active <= (sh_nxt[mfr_pkg::CONT_SEL_LSB +: 2] ==
                      mfr_pkg::CONT_SEL_KEEP); // [R07] [R09] [R10] [R11]
      cont_kind_r <= kind_r;
    end else if (sck_rise && last && state_r == mfr_pkg::ST_CMD &&
                 cmd_byte == mfr_pkg::CMD_CONT_RESET) begin
      cont_active <= 1'b0; // [R11]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrap_bits_r <= mfr_pkg::WRAP_RST; // [R20]
    end else if (wrap_set_stb) begin
      wrap_bits_r <= wrap_setting_bits; // [R17] [R19]
    end
  end

  // Fetch side: one read outstanding, at most two bytes ahead
  assign flush = frame_start | frame_end;
  assign hs = mem_rvalid & mem_rready;
  // No request at a frame edge; its address would be stale
  assign issue = fetch_on_r & ~inflight_r & ~flush &
                 (pend_r < mfr_pkg::PEND_MAX);
  assign pop = sck_fall & (state_r == mfr_pkg::ST_DATA) &
               (dcnt_r == 2'h0) & buf_valid;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_on_r <= 1'b0;
      wrap_on_r <= 1'b0;
      fetch_addr_r <= 24'h000000;
      mem_rd <= 1'b0;
      mem_addr <= 24'h000000;
    end else begin
      mem_rd <= issue;
      if (flush) begin
        fetch_on_r <= 1'b0;
      end else if (sck_rise && last && state_r == mfr_pkg::ST_ADDR) begin
        fetch_on_r <= 1'b1;
        fetch_addr_r <= sh_nxt;
        wrap_on_r <= (kind_r == mfr_pkg::KIND_QIO) &&
                     !wrap_bits_r[mfr_pkg::WRAP_DIS_BIT]; // [R17] [R19]
      end else if (issue) begin
        mem_addr <= fetch_addr_r;
        fetch_addr_r <= next_addr(fetch_addr_r, wrap_on_r,
                          wrap_bits_r[mfr_pkg::WRAP_LEN_LSB +: 2]); // [R22]
      end
    end
  end

  // A word still in flight at deselect is dropped on arrival
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      inflight_r <= 1'b0;
      drop_r <= 1'b0;
      pend_r <= 2'h0;
    end else begin
      if (issue) begin
        inflight_r <= 1'b1;
      end else if (hs) begin
        inflight_r <= 1'b0;
      end
      if (hs) begin
        drop_r <= 1'b0;
      end else if (flush && inflight_r) begin
        drop_r <= 1'b1;
      end
      if (flush) begin
        pend_r <= 2'h0;
      end else begin
        pend_r <= 2'(pend_r + 2'(issue) - 2'(pop));
      end
    end
  end

  mfr_buf u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .flush(flush),
    .in_valid(mem_rvalid & ~drop_r),
    .in_data(mem_rdata),
    .in_ready(mem_rready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(pop)
  );

  // Data out on falling edges; an underrun sends zeros
  assign x4 = (kind_r != mfr_pkg::KIND_DIO);
  assign src = (dcnt_r != 2'h0) ? dsr_r : (buf_valid ? buf_data : 8'h00);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      dcnt_r <= 2'h0;
      dsr_r <= 8'h00;
    end else if (state_r != mfr_pkg::ST_DATA) begin
      io_out <= 4'h0;
      io_oe <= 4'h0; // [R04] [R24]
      dcnt_r <= 2'h0;
    end else if (sck_fall) begin
      if (x4) begin
        io_out <= src[7:4];
        io_oe <= mfr_pkg::LANES_X4; // [R01] [R14]
        dsr_r <= {src[3:0], 4'h0};
      end else begin
        io_out <= {2'h0, src[7:6]};
        io_oe <= mfr_pkg::LANES_X2; // [R06]
        dsr_r <= {src[5:0], 2'h0};
      end
      if (dcnt_r == 2'h0) begin
        dcnt_r <= x4 ? mfr_pkg::BYTE_CLKS_X4 : mfr_pkg::BYTE_CLKS_X2;
      end else begin
        dcnt_r <= 2'(dcnt_r - 2'h1);
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_qout_refused;
    (state_r == mfr_pkg::ST_CMD) && sck_rise && last && !quad_enable_bit
      && cmd_byte == mfr_pkg::CMD_QUAD_OUT |=> state_r == mfr_pkg::ST_IGNORE;
  endproperty
  a_qout_refused: assert property (p_qout_refused) // [R02]
    else $error("quad-output read taken without quad enable");

  property p_qio_refused;
    (state_r == mfr_pkg::ST_CMD) && sck_rise && last && !quad_enable_bit
      && cmd_byte == mfr_pkg::CMD_QUAD_IO |=> state_r == mfr_pkg::ST_IGNORE;
  endproperty
  a_qio_refused: assert property (p_qio_refused) // [R15]
    else $error("quad io read taken without quad enable");

  property p_ignore_quiet;
    state_r == mfr_pkg::ST_IGNORE |-> io_oe == 4'h0 ##1 io_oe == 4'h0;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) // [R24]
    else $error("lines driven in ignored frame");

  property p_qout_dummy;
    (state_r == mfr_pkg::ST_ADDR) && sck_rise && last && !var_latency_en
      && kind_r == mfr_pkg::KIND_QOUT
      |=> state_r == mfr_pkg::ST_DUMMY && len_r == 5'h08;
  endproperty
  a_qout_dummy: assert property (p_qout_dummy) // [R03]
    else $error("quad-output dummy count not eight");

  property p_var_dummy;
    (state_r == mfr_pkg::ST_ADDR) && sck_rise && last && var_latency_en
      && kind_r == mfr_pkg::KIND_QOUT && read_latency != 4'h0
      |=> len_r == {1'b0, $past(read_latency)};
  endproperty
  a_var_dummy: assert property (p_var_dummy) // [R05]
    else $error("quad-output dummy not from latency field");

  property p_dio_latency;
    (state_r == mfr_pkg::ST_ADDR) && sck_rise && last && !var_latency_en
      && kind_r == mfr_pkg::KIND_DIO
      |=> state_r == mfr_pkg::ST_MODE && len_r == 5'h04;
  endproperty
  a_dio_latency: assert property (p_dio_latency) // [R12]
    else $error("dual io latency not four mode clocks");

  property p_qio_latency;
    (state_r == mfr_pkg::ST_MODE) && sck_rise && last && !var_latency_en
      && kind_r == mfr_pkg::KIND_QIO
      |=> state_r == mfr_pkg::ST_DUMMY && len_r == 5'h04;
  endproperty
  a_qio_latency: assert property (p_qio_latency) // [R16]
    else $error("quad io dummy not four clocks");

  property p_cont_skip;
    frame_start && cont_active && !f_r[mfr_pkg::PIN_CS]
      |=> state_r == mfr_pkg::ST_ADDR && cnt_r == 5'h00;
  endproperty
  a_cont_skip: assert property (p_cont_skip) // [R09]
    else $error("continuous frame did not start at address");

  property p_cont_exit;
    (state_r == mfr_pkg::ST_MODE) && sck_rise && last
      && sh_nxt[5:4] != 2'h2 |=> !cont_active;
  endproperty
  a_cont_exit: assert property (p_cont_exit) // [R10]
    else $error("continuous mode kept with select not 10");

  property p_lanes;
    state_r == mfr_pkg::ST_DATA && io_oe != 4'h0 |->
      io_oe == ((kind_r == mfr_pkg::KIND_DIO) ? 4'h3 : 4'hf);
  endproperty
  a_lanes: assert property (p_lanes) // [R01] [R06]
    else $error("wrong output lanes in data phase");

  property p_wrap_bound;
    issue && wrap_on_r |=>
      fetch_addr_r[23:6] == $past(fetch_addr_r[23:6]);
  endproperty
  a_wrap_bound: assert property (p_wrap_bound) // [R18]
    else $error("wrapped read left its section");

  property p_seq_addr;
    issue && !wrap_on_r |=>
      fetch_addr_r == 24'($past(fetch_addr_r) + 24'h000001);
  endproperty
  a_seq_addr: assert property (p_seq_addr) // [R22]
    else $error("sequential read address did not advance");

  c_qio_data: cover property (state_r == mfr_pkg::ST_DATA
                              && kind_r == mfr_pkg::KIND_QIO);
  c_cont_frame: cover property (frame_start && cont_active);
  c_refused: cover property (state_r == mfr_pkg::ST_IGNORE);
  c_wrap_read: cover property (issue && wrap_on_r);

endmodule

`default_nettype wire

// *** verif/mfr_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module mfr_host (
  output logic sck,
  output logic cs_n,
  output logic [3:0] drv,
  output logic [3:0] oe,
  input wire logic [3:0] io
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    drv = 4'h0;
    oe = 4'h0;
  end

  // Bits change only while sck is low, MSB first
  task automatic send(input logic [31:0] d, input int n, input int w,
                      input logic [3:0] en);
    for (int i = n - 1; i >= 0; i--) begin
      oe = en;
      drv = 4'((d >> (i * w)) & ((32'h1 << w) - 1));
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
  endtask

  // Late sample: device output lags the falling edge
  task automatic get(input int w, output logic [7:0] b);
    logic [3:0] m;
    m = 4'((32'h1 << w) - 1);
    oe = 4'h0;
    for (int i = 0; i < 8 / w; i++) begin
      #100 sck = 1'b1;
      #99 b = (b << w) | 8'(io & m);
      #1 sck = 1'b0;
    end
  endtask

  task automatic frame(input logic on);
    oe = 4'h0;
    #100 cs_n = ~on;
    #100;
  endtask
endmodule

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic ref_clk, arst_n, sck, cs_n, qe, vl, wstb, mem_rvalid, took, junk;
  logic mem_rd, mem_rready, cont, pend;
  logic [3:0] hdrv, hoe, io_in, io_out, io_oe, lat;
  logic [2:0] wbits;
  logic [7:0] mem_rdata, b;
  logic [23:0] mem_addr, pa;
  int errors, num_checks;

  // Nobody driving: a toggling level, never a stale one
  assign io_in = (io_oe & io_out) | (~io_oe & hoe & hdrv) |
                 (~io_oe & ~hoe & {4{junk}});

  mfr_host host (.sck(sck), .cs_n(cs_n), .drv(hdrv), .oe(hoe), .io(io_in));
  mfr_engine dut (.ref_clk(ref_clk), .arst_n(arst_n), .spi_clk_pin(sck),
    .spi_cs_n_pin(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .quad_enable_bit(qe), .var_latency_en(vl), .read_latency(lat),
    .wrap_set_stb(wstb), .wrap_setting_bits(wbits), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .mem_rready(mem_rready), .cont_active(cont));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Array model: data held until taken
  always @(posedge ref_clk) took <= mem_rvalid & mem_rready;
  always @(negedge ref_clk) begin
    junk <= ~junk;
    if (mem_rd) begin
      pend <= 1'b1;
      pa <= mem_addr;
    end
    if (took) mem_rvalid <= 1'b0;
    else if (pend && !mem_rvalid) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= pa[7:0] ^ 8'h5a;
      pend <= 1'b0;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input int w, input logic [23:0] a);
    host.get(w, b);
    chk(b, a[7:0] ^ 8'h5a);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    results();
  end

  initial begin
    {arst_n, qe, vl, wstb, mem_rvalid, took, pend, junk} = '0;
    lat = 4'h5;
    wbits = 3'h1;
    mem_rdata = 8'h00;
    errors = 0;
    num_checks = 0;
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    host.frame(1);
    host.send(32'h6b000010, 32, 1, 4'h1); // Refused
    host.send(0, 8, 1, 4'h0);
    host.get(4, b);
    chk({4'h0, io_oe}, 8'h00); // Lines stay free
    host.frame(0);
    $display("refusal test done");
    @(negedge ref_clk) qe = 1'b1;
    host.frame(1);
    host.send(32'h6b0000fe, 32, 1, 4'h1); // One line
    host.send(0, 8, 4, 4'h0); // Default dummies
    rd(4, 24'h0000fe); // Four lines out
    rd(4, 24'h0000ff); // Next byte
    host.frame(0);
    @(negedge ref_clk) vl = 1'b1;
    host.frame(1);
    host.send(32'h6b000020, 32, 1, 4'h1);
    host.send(0, 5, 4, 4'h0); // Field sets dummies
    rd(4, 24'h000020); // Latency from field
    host.frame(0);
    @(negedge ref_clk) vl = 1'b0;
    host.frame(1);
    host.send(32'hbb, 8, 1, 4'h1);
    host.send(32'h123456, 12, 2, 4'h3); // Two lines
    host.send(0, 2, 2, 4'h3);
    host.send(0, 2, 2, 4'h0); // Low nibble undriven
    rd(2, 24'h123456); // Four mode clocks
    rd(2, 24'h123457); // Next byte
    host.frame(0);
    $display("single and dual tests done");
    host.frame(1);
    host.send(32'heb, 8, 1, 4'h1);
    host.send(32'h00003e2, 7, 4, 4'hf); // Select 10
    host.send(0, 5, 4, 4'h0); // Two mode plus four dummy
    rd(4, 24'h00003e); // Quad io data
    rd(4, 24'h00003f); // Wrap off from reset
    rd(4, 24'h000040); // Crosses section
    host.frame(0);
    chk({7'h0, cont}, 8'h01); // Armed
    host.frame(1);
    host.send(32'h0000100, 7, 4, 4'hf); // No instruction
    host.send(0, 5, 4, 4'h0);
    rd(4, 24'h000010); // Address first
    host.frame(0);
    chk({7'h0, cont}, 8'h00); // Select 00 leaves
    @(negedge ref_clk);
    wstb = 1'b1;
    wbits = 3'h2;
    @(negedge ref_clk) wstb = 1'b0;
    host.frame(1);
    host.send(32'heb, 8, 1, 4'h1);
    host.send(32'h00001e2, 7, 4, 4'hf);
    host.send(0, 5, 4, 4'h0);
    rd(4, 24'h00001e); // Wrap on
    rd(4, 24'h00001f); // Section end
    rd(4, 24'h000010); // Back to 16 byte start
    host.frame(0);
    chk({7'h0, cont}, 8'h01); // Armed again
    host.frame(1);
    host.send(32'hffffffff, 8, 4, 4'hf); // Eight clocks quad
    host.frame(0);
    chk({7'h0, cont}, 8'h00); // Mode cleared
    @(negedge ref_clk);
    vl = 1'b1;
    lat = 4'ha;
    wstb = 1'b1;
    wbits = 3'h4;
    @(negedge ref_clk) wstb = 1'b0;
    host.frame(1);
    host.send(32'hbb, 8, 1, 4'h1);
    host.send(32'h0000bf, 12, 2, 4'h3);
    host.send(0, 2, 2, 4'h3);
    host.send(0, 8, 2, 4'h0); // Four mode plus six dummy
    rd(2, 24'h0000bf); // Dual latency from field
    rd(2, 24'h0000c0); // Dual never wraps
    host.frame(0);
    host.frame(1);
    host.send(32'heb, 8, 1, 4'h1);
    host.send(32'h00003e0, 7, 4, 4'hf);
    host.send(0, 9, 4, 4'h0); // Two mode plus eight dummy
    rd(4, 24'h00003e); // Quad latency from field
    rd(4, 24'h00003f); // 32 byte section end
    rd(4, 24'h000020); // Back to 32 byte start
    host.frame(0);
    chk({7'h0, cont}, 8'h00); // Select 00 stays normal
    $display("quad io tests done");
    results();
  end
endmodule

`default_nettype wire
